// File: flash_host_ctrl.v
`timescale 1ns/1ps
`include "flash_host_defs.vh"
module flash_host_ctrl (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Flash control pins
  output reg chipEnableN,
  output reg outputEnableN,
  output reg writeEnableN,
  output reg oeHighVoltage,
  output reg addrBit9HighVoltage,
  output reg resetHighVoltage,
  output reg [`ADDR_W-1:0] flashAddr,
  // Flash data bus, two-way
  input wire [15:0] flashDataIn,
  output reg [15:0] flashDataOut,
  output reg flashDataOe,
  // Ready/busy, open drain from device
  input wire readyBusyN
);
  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam S_IDLE = 6'b000001;
  localparam S_SETUP = 6'b000010;
  localparam S_PULSE = 6'b000100;
  localparam S_RECOV = 6'b001000;
  localparam S_SAMPLE = 6'b010000;
  localparam S_DONE = 6'b100000;

  reg [5:0] state_ff;
  reg [2:0] op_ff;
  reg [15:0] wdata_ff;
  reg [15:0] rdata_ff;
  reg [15:0] prevData_ff;
  reg havePrev_ff;
  reg busy_ff;
  reg doneFlag_ff;
  reg fail_ff;
  reg window_ff;
  reg [15:0] dIn1_ff;
  reg [15:0] dIn2_ff;
  reg rb1_ff;
  reg rb2_ff;
  reg timerStart;
  reg [`CNT_W-1:0] timerLen;
  wire timerDone;

  function isWriteOp;
    input [2:0] op;
    begin
      isWriteOp = (op == `OP_WRITE) || (op == `OP_PROTECT) || (op == `OP_UNPROTECT);
    end
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dIn1_ff <= 16'h0000;
      dIn2_ff <= 16'h0000;
      rb1_ff <= 1'b1;
      rb2_ff <= 1'b1;
    end else begin
      dIn1_ff <= flashDataIn;
      dIn2_ff <= dIn1_ff;
      rb1_ff <= readyBusyN;
      rb2_ff <= rb1_ff;
    end
  end

  pulse_timer u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(timerStart),
    .len(timerLen),
    .done(timerDone)
  );

  // ------------------------------------------------------------
  // APB slave, zero wait states
  // ------------------------------------------------------------
  wire apbWr = psel && penable && pwrite;
  wire cmdHit = apbWr && (paddr == `REG_CMD) && (state_ff == S_IDLE);
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always @* begin
    case (paddr)
      `REG_CMD: prdata = {29'h0, op_ff};
      `REG_ADDR: prdata = {12'h000, flashAddr};
      `REG_WDATA: prdata = {16'h0000, wdata_ff};
      `REG_STATUS: prdata = {26'h0, resetHighVoltage, rb2_ff, window_ff, fail_ff,
                             doneFlag_ff, busy_ff};
      `REG_RDATA: prdata = {16'h0000, rdata_ff};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always @* begin
    timerStart = 1'b0;
    timerLen = `PULSE_LEN;
    if (state_ff == S_IDLE && cmdHit && pwdata[2:0] != `OP_TEMP) begin
      timerStart = 1'b1;
    end else if (state_ff == S_SETUP || state_ff == S_PULSE || state_ff == S_RECOV) begin
      timerStart = timerDone && state_ff != S_RECOV;
      // High-voltage protect operations need a longer write pulse
      if (state_ff == S_SETUP && (op_ff == `OP_PROTECT || op_ff == `OP_UNPROTECT))
        timerLen = `HVPULSE_LEN;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= S_IDLE;
      op_ff <= 3'h0;
      wdata_ff <= 16'h0000;
      rdata_ff <= 16'h0000;
      prevData_ff <= 16'h0000;
      havePrev_ff <= 1'b0;
      busy_ff <= 1'b0;
      doneFlag_ff <= 1'b0;
      fail_ff <= 1'b0;
      window_ff <= 1'b0;
      chipEnableN <= 1'b1;
      outputEnableN <= 1'b1;
      writeEnableN <= 1'b1;
      oeHighVoltage <= 1'b0;
      addrBit9HighVoltage <= 1'b0;
      resetHighVoltage <= 1'b0;
      flashAddr <= {`ADDR_W{1'b0}};
      flashDataOut <= 16'h0000;
      flashDataOe <= 1'b0;
    end else begin
      if (apbWr && paddr == `REG_ADDR && state_ff == S_IDLE)
        flashAddr <= pwdata[`ADDR_W-1:0];
      if (apbWr && paddr == `REG_WDATA && state_ff == S_IDLE)
        wdata_ff <= pwdata[15:0];
      case (state_ff)
        S_IDLE: begin
          if (cmdHit) begin
            op_ff <= pwdata[2:0];
            doneFlag_ff <= 1'b0;
            if (pwdata[2:0] == `OP_TEMP) begin
              resetHighVoltage <= pwdata[8];
              doneFlag_ff <= 1'b1;
            end else begin
              busy_ff <= 1'b1;
              chipEnableN <= 1'b0;
              // Levels settle before the strobe so no glitch starts a write
              addrBit9HighVoltage <= (pwdata[2:0] == `OP_PROTECT) ||
                                     (pwdata[2:0] == `OP_VERIFY) ||
                                     (pwdata[2:0] == `OP_UNPROTECT);
              oeHighVoltage <= (pwdata[2:0] == `OP_PROTECT) ||
                               (pwdata[2:0] == `OP_UNPROTECT);
              if (pwdata[2:0] == `OP_UNPROTECT)
                flashAddr[6] <= 1'b1;
              if (pwdata[2:0] == `OP_VERIFY) begin
                flashAddr[1] <= 1'b1;
                flashAddr[0] <= 1'b0;
                flashAddr[6] <= 1'b0;
              end
              flashDataOe <= isWriteOp(pwdata[2:0]);
              flashDataOut <= wdata_ff;
              state_ff <= S_SETUP;
            end
          end
        end
        S_SETUP: begin
          if (timerDone) begin
            if (isWriteOp(op_ff))
              writeEnableN <= 1'b0;
            else
              outputEnableN <= 1'b0;
            state_ff <= S_PULSE;
          end
        end
        S_PULSE: begin
          if (timerDone) begin
            if (!isWriteOp(op_ff)) begin
              rdata_ff <= dIn2_ff;
              state_ff <= S_SAMPLE;
            end else begin
              state_ff <= S_RECOV;
            end
            writeEnableN <= 1'b1;
            outputEnableN <= 1'b1;
          end
        end
        S_SAMPLE: begin
          // Two reads in a row decide whether toggle bit DQ_TGL1 moves
          if (op_ff == `OP_POLL) begin
            havePrev_ff <= 1'b1;
            prevData_ff <= rdata_ff;
            window_ff <= rdata_ff[`DQ_WIN];
            if (havePrev_ff && prevData_ff[`DQ_TGL1] == rdata_ff[`DQ_TGL1]) begin
              fail_ff <= 1'b0;
              havePrev_ff <= 1'b0;
            end else if (havePrev_ff && rdata_ff[`DQ_TOUT]) begin
              fail_ff <= 1'b1;
              havePrev_ff <= 1'b0;
            end
          end
          state_ff <= S_DONE;
        end
        S_RECOV: begin
          state_ff <= S_DONE;
        end
        S_DONE: begin
          chipEnableN <= 1'b1;
          oeHighVoltage <= 1'b0;
          addrBit9HighVoltage <= 1'b0;
          flashDataOe <= 1'b0;
          busy_ff <= 1'b0;
          doneFlag_ff <= 1'b1;
          state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule // flash_host_ctrl

// File: flash_host_defs.vh
// Functional notes
// - Host writes reset command sequence after a timeout before new operations; the controller only sets ST_FAIL and keeps accepting commands.
// - Host presents program address or erasing-sector address when polling status.
// - Host checks window bit before and after each added sector erase command.
// - Write needs chip and write enable low with output enable high.
// - High voltage level on reset pin temporarily unprotects protected sectors.
// - Sector protect write spans write enable falling edge to rising edge.
// - Chip unprotect: high levels on output enable and bit9, bit6 high, pulse.
// - Protect all sectors before chip unprotect; a recommendation; OP_UNPROTECT does not protect them first.
`ifndef FLASH_HOST_DEFS_VH
`define FLASH_HOST_DEFS_VH
// APB register offsets
`define REG_CMD 12'h000
`define REG_ADDR 12'h004
`define REG_WDATA 12'h008
`define REG_STATUS 12'h00c
`define REG_RDATA 12'h010
// Command codes in REG_CMD[2:0]
`define OP_READ 3'h1
`define OP_WRITE 3'h2
`define OP_POLL 3'h3
`define OP_PROTECT 3'h4
`define OP_VERIFY 3'h5
`define OP_UNPROTECT 3'h6
`define OP_TEMP 3'h7
// Status bits
`define ST_BUSY 0
`define ST_DONE 1
`define ST_FAIL 2
`define ST_WINDOW 3
`define ST_READY 4
`define ST_TEMP 5
// Flash status bit positions
`define DQ_POLL 7
`define DQ_TGL1 6
`define DQ_TOUT 5
`define DQ_WIN 3
`define DQ_TGL2 2
// Timing: normal and high-voltage pulse widths in ns, derived cycles at 5 ns
`define CLK_NS 5
`define PULSE_NS 40
`define PULSE_CYC ((`PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define HVPULSE_NS 100
`define HVPULSE_CYC ((`HVPULSE_NS + `CLK_NS - 1) / `CLK_NS)
// Counter-width loads of the two pulse lengths above (8 and 20 cycles)
`define PULSE_LEN 8'h08
`define HVPULSE_LEN 8'h14
`define CNT_ONE 8'h01
`define ADDR_W 20
`define CNT_W 8
`endif

// File: pulse_timer.v
`timescale 1ns/1ps
`include "flash_host_defs.vh"
module pulse_timer (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Control
  input wire start,
  input wire [`CNT_W-1:0] len,
  output wire done
);
  reg [`CNT_W-1:0] cnt_ff;
  reg run_ff;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= {`CNT_W{1'b0}};
      run_ff <= 1'b0;
    end else if (start) begin
      cnt_ff <= len;
      run_ff <= 1'b1;
    end else if (run_ff) begin
      cnt_ff <= cnt_ff - 1'b1;
      if (cnt_ff == `CNT_ONE)
        run_ff <= 1'b0;
    end
  end
  assign done = run_ff && (cnt_ff == `CNT_ONE);
endmodule // pulse_timer

// File: flash_host_ctrl_monitor.sv
`timescale 1ns/1ps
`include "flash_host_defs.vh"
module flash_host_ctrl_monitor (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Flash pins
  input wire chipEnableN,
  input wire outputEnableN,
  input wire writeEnableN,
  input wire oeHighVoltage,
  input wire addrBit9HighVoltage,
  input wire [`ADDR_W-1:0] flashAddr,
  input wire [15:0] flashDataOut,
  input wire flashDataOe
);
  // ----
  // Strobe checks
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_low8;
    (!writeEnableN)[*8];
  endsequence
  a_write_inhibit: assert property (!writeEnableN |-> outputEnableN || oeHighVoltage)
    else $error("write strobe with output enable low");
  a_ce_setup: assert property ($fell(writeEnableN) |-> !$past(chipEnableN) && !chipEnableN)
    else $error("write strobe without chip enable");
  a_data_held: assert property (!writeEnableN && !addrBit9HighVoltage |->
    flashDataOe && $stable(flashDataOut))
    else $error("write data not driven steady");
  a_read_addr: assert property (!outputEnableN |-> $stable(flashAddr))
    else $error("address moved during read");
  a_write_width: assert property ($fell(writeEnableN) && !addrBit9HighVoltage |->
    s_low8 ##1 writeEnableN)
    else $error("write pulse width wrong");
  a_prot_span: assert property ($fell(writeEnableN) && addrBit9HighVoltage |->
    oeHighVoltage throughout s_low8)
    else $error("protect pulse too short");
  a_hv_at_rise: assert property (!writeEnableN && oeHighVoltage |=> oeHighVoltage)
    else $error("high level dropped before strobe rise");
  a_unprot_pair: assert property (oeHighVoltage |-> addrBit9HighVoltage)
    else $error("output enable high level without address high level");
endmodule // flash_host_ctrl_monitor
bind flash_host_ctrl flash_host_ctrl_monitor M (.ref_clk, .rst, .chipEnableN, .outputEnableN,
  .writeEnableN, .oeHighVoltage, .addrBit9HighVoltage, .flashAddr, .flashDataOut, .flashDataOe);

// File: flash_dev_model.sv
`timescale 1ns/1ps
module flash_dev_model #(
  parameter BUSY_NS = 1000,
  parameter [15:0] ID_CODE = 16'h00c3
) (
  // Strobes and levels
  input wire chipEnableN,
  input wire outputEnableN,
  input wire writeEnableN,
  input wire oeHighVoltage,
  input wire addrBit9HighVoltage,
  input wire resetHighVoltage,
  // Address, data and ready/busy
  input wire [19:0] flashAddr,
  input wire [15:0] flashDataOut,
  output wire [15:0] flashDataIn,
  output wire readyBusyN
);
  // ----
  // Behaviour
  // ----
  reg [15:0] mem [0:255];
  reg [15:0] prot = 16'h0;
  reg [15:0] pdata = 16'h0;
  reg [15:0] bus = 16'h0;
  reg busy = 0;
  reg tgl = 0;
  reg armed = 0;
  realtime t0 = 0;
  integer i;
  wire [3:0] sec = flashAddr[19:16];
  wire [7:0] ix = {sec, flashAddr[3:0]};
  // ID_CODE is arbitrary; verify mode looks only at address bit 1 and the sector bits
  wire [15:0] val = addrBit9HighVoltage ? (flashAddr[1] ? {15'h0, prot[sec]} : ID_CODE)
    : busy ? {8'h00, ~pdata[7], tgl, 6'h00} : mem[ix];
  assign flashDataIn = (!chipEnableN && !outputEnableN) ? val : bus;
  assign readyBusyN = !busy;
  initial begin
    for (i = 0; i < 256; i = i + 1) mem[i] = 16'hffff;
  end
  // Released bus shows the inverse so a stale sample cannot pass
  always @(posedge outputEnableN) bus <= ~val;
  always @(negedge outputEnableN) if (busy && !chipEnableN) tgl <= ~tgl;
  always @(negedge writeEnableN) t0 = $realtime;
  always @(posedge writeEnableN) begin
    if (!chipEnableN && (outputEnableN || oeHighVoltage) && $realtime - t0 >= 5.0 && !busy) begin
      if (addrBit9HighVoltage && oeHighVoltage) begin
        if (flashAddr[6]) prot <= 16'h0;
        else prot[sec] <= 1'b1;
      end else if (armed) begin
        armed <= 0;
        if (!prot[sec] || resetHighVoltage) begin
          mem[ix] <= mem[ix] & flashDataOut;
          pdata <= flashDataOut;
          busy <= 1;
          #BUSY_NS busy <= 0;
        end
      end else armed <= (flashDataOut[7:0] == 8'ha0);
    end
  end
endmodule // flash_dev_model

// File: flash_host_ctrl_tb.sv
`timescale 1ns/1ps
`include "flash_host_defs.vh"
module flash_host_ctrl_tb;
  logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, r, p1;
  wire [31:0] prdata;
  wire pready, pslverr, chipEnableN, outputEnableN, writeEnableN, oeHighVoltage;
  wire addrBit9HighVoltage, resetHighVoltage, flashDataOe, readyBusyN;
  wire [`ADDR_W-1:0] flashAddr;
  wire [15:0] flashDataIn, flashDataOut;
  integer errors = 0, compares = 0;
  flash_host_ctrl DUT (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .chipEnableN, .outputEnableN, .writeEnableN, .oeHighVoltage,
    .addrBit9HighVoltage, .resetHighVoltage, .flashAddr, .flashDataIn, .flashDataOut,
    .flashDataOe, .readyBusyN);
  flash_dev_model DEV (.chipEnableN, .outputEnableN, .writeEnableN, .oeHighVoltage,
    .addrBit9HighVoltage, .resetHighVoltage, .flashAddr, .flashDataOut, .flashDataIn,
    .readyBusyN);
  // ----
  // Tasks
  // ----
  task report_and_stop;
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  // Bounded wait on one status bit; a stuck bit counts as a mismatch
  task waitst(input integer b, input logic v);
    integer n;
    n = 0;
    do begin
      apb(0, `REG_STATUS, 0);
      n++;
    end while (r[b] !== v && n < 500);
    if (n >= 500) begin
      errors++;
      report_and_stop;
    end
  endtask
  task cmd(input logic [31:0] op, input logic [19:0] a, input logic [15:0] d);
    apb(1, `REG_ADDR, {12'h0, a});
    apb(1, `REG_WDATA, {16'h0, d});
    apb(1, `REG_CMD, op);
    waitst(`ST_BUSY, 1'b0);
    apb(0, `REG_RDATA, 0);
  endtask
  task prog(input logic [19:0] a, input logic [15:0] d);
    cmd(`OP_WRITE, 20'h00555, 16'h00a0);
    cmd(`OP_WRITE, a, d);
  endtask
  // ----
  // Scenarios
  // ----
  task t_idle;
    apb(0, `REG_STATUS, 0);
    cmp("status", 32'h10, r);
    apb(0, 12'h020, 0);
    cmp("unmapped", 32'h0, r);
    cmd(`OP_READ, 20'h00004, 0);
    cmp("blank", 32'hffff, r);
  endtask
  task t_protect;
    cmd(`OP_PROTECT, 20'h10000, 0);
    cmd(`OP_VERIFY, 20'h10002, 0);
    cmp("prot1", 32'h1, r);
    cmd(`OP_VERIFY, 20'h20002, 0);
    cmp("prot2", 32'h0, r);
    prog(20'h10004, 16'h1234);
    cmd(`OP_READ, 20'h10004, 0);
    cmp("refused", 32'hffff, r);
  endtask
  task t_temp;
    cmd(32'h107, 20'h0, 0);
    apb(0, `REG_STATUS, 0);
    cmp("temp", 32'h1, {31'h0, r[`ST_TEMP]});
    prog(20'h10004, 16'h1234);
    waitst(`ST_READY, 1'b1);
    cmd(`OP_READ, 20'h10004, 0);
    cmp("tempprog", 32'h1234, r);
    cmd(32'h007, 20'h0, 0);
    prog(20'h10008, 16'h0);
    cmd(`OP_READ, 20'h10008, 0);
    cmp("reprot", 32'hffff, r);
  endtask
  task t_poll;
    prog(20'h20004, 16'h5a80);
    cmd(`OP_POLL, 20'h20004, 0);
    p1 = r;
    cmp("poll7", 32'h0, {31'h0, r[`DQ_POLL]});
    cmd(`OP_POLL, 20'h20004, 0);
    cmp("toggle", {31'h0, ~p1[`DQ_TGL1]}, {31'h0, r[`DQ_TGL1]});
    apb(0, `REG_STATUS, 0);
    cmp("pollst", 32'h0, {30'h0, r[`ST_WINDOW], r[`ST_FAIL]});
    waitst(`ST_READY, 1'b1);
    cmd(`OP_READ, 20'h20004, 0);
    cmp("data", 32'h5a80, r);
    prog(20'h20004, 16'hffff);
    waitst(`ST_READY, 1'b1);
    cmd(`OP_READ, 20'h20004, 0);
    cmp("nochange", 32'h5a80, r);
  endtask
  task t_unprot;
    cmd(`OP_UNPROTECT, 20'h00040, 0);
    cmd(`OP_VERIFY, 20'h10002, 0);
    cmp("unprot", 32'h0, r);
  endtask
  initial forever #2.5 ref_clk = ~ref_clk;
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 0;
    t_idle;
    t_protect;
    t_temp;
    t_poll;
    t_unprot;
    report_and_stop;
  end
  initial begin
    #100000;
    errors++;
    report_and_stop;
  end
endmodule // flash_host_ctrl_tb
